// ===== logic/scs_clock_ctrl.sv
// System clock selection, domain gating and start-up sequencing.
// Assumes oscillator ticks and fuse levels are synchronous to clk_i; the
// domain outputs are enables/ticks, not real clocks.
`timescale 1ns/1ns

// Overview of operation
// RQ1: Codes 1111-1000 crystal, 0010 RC, 0000 external clock; PLL fed from RC.
// RQ2: Codes 0011, 0001, 0101 run system at PLL/4; PLL from RC, ext clock, crystal.
// RQ3: Code 0100 clocks system from crystal and feeds crystal into PLL.
// RQ4: Fuse bit one means unprogrammed, zero means programmed.
// RQ5: PLL clocks power stage at 64 or 32 MHz; 16 MHz derived for core.
// RQ6: Wake from power-down/save timed by selected source; run only when stable.
// RQ7: Reset start-up adds a supply-settle delay counted on watchdog oscillator.
// RQ8: Reset time-out is 4096 or 65536 watchdog oscillator cycles.
// RQ9: Converter clock keeps running while core and peripheral clocks halt.
// RQ10: Program memory clock gates together with core clock.
// RQ11: Some external interrupts detected without the peripheral clock.
// RQ12: Clock domains stopped selectively per sleep mode.
// RQ13: Peripheral clock drives timers, serial ports and interrupt unit.
// RQ14: Halted core clock stops all core activity until it resumes.
// RQ15: Default RC selection with prescale by eight when that fuse is programmed.
// RQ16: Reserved codes 0111 and 0110 must not be programmed.
module scs_clock_ctrl #(
   parameter int unsigned RESET_SHORT = scs_pkg::RESET_SHORT_CYCLES,
   parameter int unsigned RESET_LONG = scs_pkg::RESET_LONG_CYCLES,
   parameter int unsigned WAKE_COUNT = scs_pkg::WAKE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] clock_source_select_code_i,
   input wire logic divide_by_eight_fuse_i,
   input wire logic long_reset_timeout_i,
   input wire logic ext_osc_tick_i,
   input wire logic rc_osc_tick_i,
   input wire logic ext_clk_tick_i,
   input wire logic pll_tick_i,
   input wire logic pll_half_rate_i,
   input wire logic watchdog_tick_i,
   input wire logic osc_stable_i,
   input wire logic sleep_req_i,
   input wire scs_pkg::scs_sleep_t sleep_mode_i,
   input wire logic wake_i,
   input wire logic async_irq_i,
   output logic [2:0] pll_input_src_o,
   output logic system_tick_o,
   output logic core_clock_o,
   output logic program_memory_clock_o,
   output logic peripheral_clock_o,
   output logic converter_clock_o,
   output logic fast_multiplied_clock_o,
   output logic core_run_o,
   output logic irq_wake_o,
   output logic code_reserved_o
);
   import scs_pkg::*;

   // ---------------------------------------------------------------
   // Fuse decoding
   // ---------------------------------------------------------------
   function automatic scs_src_t sys_src(input logic [3:0] code);
      if (code >= SEL_XTAL_LO || code == SEL_XTAL_PLL_DIRECT) return SRC_EXT_OSC; // [RQ1] [RQ3]
      unique case (code)
         SEL_RC: return SRC_RC; // [RQ1]
         SEL_EXTCLK: return SRC_EXT_CLK; // [RQ1]
         SEL_PLL4_RC, SEL_PLL4_EXTCLK, SEL_PLL4_XTAL: return SRC_PLL4; // [RQ2]
         default: return SRC_NONE; // [RQ16]
      endcase
   endfunction

   function automatic scs_src_t pll_src(input logic [3:0] code);
      unique case (code)
         SEL_PLL4_EXTCLK: return SRC_EXT_CLK; // [RQ2]
         SEL_PLL4_XTAL, SEL_XTAL_PLL_DIRECT: return SRC_EXT_OSC; // [RQ2] [RQ3]
         SEL_RSVD_HI, SEL_RSVD_LO: return SRC_NONE;
         default: return SRC_RC; // [RQ1]
      endcase
   endfunction

   typedef struct packed {
      scs_state_t st;
      scs_sleep_t mode;
      logic [CNT_W-1:0] cnt;
      logic [1:0] pll_div;
      logic [2:0] pre_div;
      logic stage_phase;
      logic [2:0] pll_in;
      logic sys_tick;
      logic core_clk;
      logic flash_clk;
      logic io_clk;
      logic adc_clk;
      logic stage_clk;
      logic core_run;
      logic irq_wake;
      logic reserved;
   } scs_regs_t;

   scs_regs_t r_q;
   scs_regs_t r_d;
   scs_src_t src;
   logic pll4_tick;
   logic src_tick;
   logic prescale_on;
   logic [CNT_W-1:0] reset_last;
   logic [CNT_W-1:0] wake_last;

   always_comb begin
      src = sys_src(clock_source_select_code_i);
      pll4_tick = pll_tick_i && r_q.pll_div == PLL_DIV_LAST; // [RQ5]
      unique case (src)
         SRC_EXT_OSC: src_tick = ext_osc_tick_i;
         SRC_RC: src_tick = rc_osc_tick_i;
         SRC_EXT_CLK: src_tick = ext_clk_tick_i;
         SRC_PLL4: src_tick = pll4_tick;
         default: src_tick = 1'b0;
      endcase
      prescale_on = divide_by_eight_fuse_i == FUSE_PROGRAMMED; // [RQ4] [RQ15]
      reset_last = long_reset_timeout_i ? CNT_W'(RESET_LONG - 1) : CNT_W'(RESET_SHORT - 1); // [RQ8]
      wake_last = CNT_W'(WAKE_COUNT - 1);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      r_d = r_q;
      r_d.reserved = src == SRC_NONE; // [RQ16]
      r_d.pll_in = pll_src(clock_source_select_code_i);
      if (pll_tick_i) begin
         r_d.pll_div = r_q.pll_div + 2'h1;
         r_d.stage_phase = ~r_q.stage_phase;
      end
      if (src_tick) begin
         r_d.pre_div = r_q.pre_div + 3'h1;
      end
      // Prescaler keeps running through sleep so the system tick resumes in phase
      r_d.sys_tick = src_tick && (!prescale_on || r_q.pre_div == PRESCALE_LAST); // [RQ15]
      r_d.stage_clk = pll_tick_i && (!pll_half_rate_i || r_q.stage_phase); // [RQ5]
      unique case (r_q.st)
         ST_RESET_WAIT: begin
            if (watchdog_tick_i) begin // [RQ7]
               r_d.cnt = r_q.cnt + CNT_W'(1);
               if (r_q.cnt == reset_last) begin // [RQ8]
                  r_d.cnt = '0;
                  r_d.st = ST_WAKE_WAIT;
               end
            end
         end
         ST_WAKE_WAIT: begin
            if (src_tick && r_q.cnt != wake_last) begin // [RQ6]
               r_d.cnt = r_q.cnt + CNT_W'(1);
            end
            if (r_q.cnt == wake_last && osc_stable_i && !r_d.reserved) begin // [RQ6]
               r_d.cnt = '0;
               r_d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (sleep_req_i) begin
               r_d.st = ST_SLEEP;
               r_d.mode = sleep_mode_i;
            end
         end
         ST_SLEEP: begin
            if (wake_i) begin
               // Oscillator was stopped only in the deep modes
               r_d.st = (r_q.mode == SLP_POWER_DOWN || r_q.mode == SLP_POWER_SAVE) ? ST_WAKE_WAIT : ST_RUN; // [RQ6]
            end
         end
      endcase
      // Domain gating per state and sleep mode
      r_d.core_run = r_d.st == ST_RUN; // [RQ14]
      r_d.core_clk = r_d.core_run && r_d.sys_tick; // [RQ14]
      r_d.flash_clk = r_d.core_clk; // [RQ10]
      r_d.io_clk = r_d.sys_tick && (r_d.core_run || (r_d.st == ST_SLEEP && r_d.mode == SLP_IDLE)); // [RQ12] [RQ13]
      r_d.adc_clk = r_d.sys_tick && (r_d.core_run || (r_d.st == ST_SLEEP
                    && (r_d.mode == SLP_IDLE || r_d.mode == SLP_ADC_QUIET))); // [RQ9] [RQ12]
      // Deep sleep stops the PLL-driven stage as well
      if (r_d.st == ST_SLEEP && (r_d.mode == SLP_POWER_DOWN || r_d.mode == SLP_POWER_SAVE)) begin
         r_d.stage_clk = 1'b0; // [RQ12]
      end
      // Wake detection needs no peripheral clock
      r_d.irq_wake = async_irq_i; // [RQ11]
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_q <= '0;
         r_q.st <= ST_RESET_WAIT; // [RQ7]
         r_q.mode <= SLP_IDLE;
         r_q.pll_in <= SRC_RC;
      end else begin
         r_q <= r_d;
      end
   end

   assign pll_input_src_o = r_q.pll_in;
   assign system_tick_o = r_q.sys_tick;
   assign core_clock_o = r_q.core_clk;
   assign program_memory_clock_o = r_q.flash_clk;
   assign peripheral_clock_o = r_q.io_clk;
   assign converter_clock_o = r_q.adc_clk;
   assign fast_multiplied_clock_o = r_q.stage_clk;
   assign core_run_o = r_q.core_run;
   assign irq_wake_o = r_q.irq_wake;
   assign code_reserved_o = r_q.reserved;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_deep_sleep;
      r_q.st == ST_SLEEP && (r_q.mode == SLP_POWER_DOWN || r_q.mode == SLP_POWER_SAVE);
   endsequence
   sequence s_wake_event;
      s_deep_sleep ##0 wake_i;
   endsequence

   a_rc_code_select: assert property (clock_source_select_code_i == SEL_RC |-> ##1 pll_input_src_o == SRC_RC) // [RQ1]
      else $error("RC code did not feed PLL from RC");
   a_pll4_extclk: assert property (clock_source_select_code_i == SEL_PLL4_EXTCLK
      |-> ##1 pll_input_src_o == SRC_EXT_CLK) // [RQ2]
      else $error("PLL input not external clock");
   a_direct_xtal: assert property (clock_source_select_code_i == SEL_XTAL_PLL_DIRECT && $stable(clock_source_select_code_i)
      |-> ##1 pll_input_src_o == SRC_EXT_OSC && !code_reserved_o) // [RQ3]
      else $error("Direct crystal code misdecoded");
   a_prescale_off: assert property (core_run_o && !prescale_on && src_tick |-> ##1 system_tick_o) // [RQ4]
      else $error("Unprogrammed prescale fuse still divides");
   a_pll_quarter: assert property (system_tick_o && src == SRC_PLL4 && $stable(src) |-> $past(pll_tick_i)) // [RQ5]
      else $error("PLL quarter tick without PLL edge");
   a_wake_timed: assert property (s_wake_event |-> ##1 r_q.st == ST_WAKE_WAIT ##1 !core_run_o) // [RQ6]
      else $error("Deep wake skipped start-up timing");
   a_reset_counts: assert property (r_q.st == ST_RESET_WAIT && !watchdog_tick_i |=> $stable(r_q.cnt)) // [RQ7]
      else $error("Reset delay counted without watchdog tick");
   a_reset_len: assert property (r_q.st == ST_RESET_WAIT && watchdog_tick_i && r_q.cnt == reset_last
      |=> r_q.st == ST_WAKE_WAIT) // [RQ8]
      else $error("Reset time-out length wrong");
   a_adc_runs: assert property (r_q.st == ST_SLEEP && r_q.mode == SLP_ADC_QUIET && r_q.sys_tick |-> converter_clock_o
      && !peripheral_clock_o) // [RQ9]
      else $error("Converter clock halted in quiet mode");
   a_flash_core: assert property (program_memory_clock_o == core_clock_o) // [RQ10]
      else $error("Program memory clock split from core");
   a_irq_async: assert property (s_deep_sleep ##0 async_irq_i |=> irq_wake_o) // [RQ11]
      else $error("Interrupt lost with peripheral clock stopped");
   a_deep_gated: assert property (s_deep_sleep |-> !peripheral_clock_o && !converter_clock_o
      && !fast_multiplied_clock_o) // [RQ12] [RQ13]
      else $error("Domain running in deep sleep");
   a_core_halt: assert property (!core_run_o |-> !core_clock_o) // [RQ14]
      else $error("Core clock while halted");
   a_prescale_eight: assert property (prescale_on && $stable(prescale_on) && system_tick_o
      |-> $past(r_q.pre_div) == PRESCALE_LAST) // [RQ15]
      else $error("Prescale by eight violated");
endmodule // scs_clock_ctrl

// ===== logic/scs_pkg.sv
// Constants and types shared by the system clock select and start-up block.
// Assumes a single 250 MHz fabric clock; every oscillator arrives as a one-cycle tick.
package scs_pkg;
   // ---------------------------------------------------------------
   // Clock source select codes (raw fuse bits, 1 = unprogrammed)
   // ---------------------------------------------------------------
   localparam logic [3:0] SEL_XTAL_LO = 4'h8;
   localparam logic [3:0] SEL_XTAL_PLL_DIRECT = 4'h4;
   localparam logic [3:0] SEL_PLL4_XTAL = 4'h5;
   localparam logic [3:0] SEL_RSVD_HI = 4'h7;
   localparam logic [3:0] SEL_RSVD_LO = 4'h6;
   localparam logic [3:0] SEL_PLL4_RC = 4'h3;
   localparam logic [3:0] SEL_RC = 4'h2;
   localparam logic [3:0] SEL_PLL4_EXTCLK = 4'h1;
   localparam logic [3:0] SEL_EXTCLK = 4'h0;
   localparam logic FUSE_PROGRAMMED = 1'b0;

   // ---------------------------------------------------------------
   // Counts and widths
   // ---------------------------------------------------------------
   localparam int CNT_W = 17;
   localparam int unsigned RESET_SHORT_CYCLES = 4096;
   localparam int unsigned RESET_LONG_CYCLES = 65536;
   localparam int unsigned WAKE_CYCLES = 16384;
   localparam logic [1:0] PLL_DIV_LAST = 2'h3;
   localparam logic [2:0] PRESCALE_LAST = 3'h7;

   typedef enum logic [2:0] {
      SRC_EXT_OSC = 3'h0,
      SRC_RC = 3'h1,
      SRC_EXT_CLK = 3'h2,
      SRC_PLL4 = 3'h3,
      SRC_NONE = 3'h4
   } scs_src_t;

   typedef enum logic [1:0] {
      SLP_IDLE = 2'h0,
      SLP_ADC_QUIET = 2'h1,
      SLP_POWER_DOWN = 2'h2,
      SLP_POWER_SAVE = 2'h3
   } scs_sleep_t;

   typedef enum logic [3:0] {
      ST_RESET_WAIT = 4'b0001,
      ST_WAKE_WAIT = 4'b0010,
      ST_RUN = 4'b0100,
      ST_SLEEP = 4'b1000
   } scs_state_t;
endpackage

// ===== testbench/scs_osc_model.sv
// Oscillator source model: every source as a one-cycle tick at a fixed rate.
// Assumes the bench clock; ticks change at its falling edge.
`timescale 1ns/1ns
module scs_osc_model (
   input wire logic clk_i,
   input wire logic stable_i,
   output logic ext_osc_tick_o,
   output logic rc_osc_tick_o,
   output logic ext_clk_tick_o,
   output logic pll_tick_o,
   output logic watchdog_tick_o,
   output logic osc_stable_o
);
   logic [7:0] cnt_q = 8'h00;
   // Crystal, watchdog and PLL/4 all tick one cycle in four; the other rates differ, so a wrong source among them shows up as a wrong tick count
   always @(negedge clk_i) begin
      cnt_q <= cnt_q + 8'h01;
      rc_osc_tick_o <= cnt_q[0];
      ext_osc_tick_o <= cnt_q[1:0] == 2'h2;
      ext_clk_tick_o <= cnt_q[2:0] == 3'h5;
      watchdog_tick_o <= cnt_q[1:0] == 2'h1;
      pll_tick_o <= 1'b1;
      osc_stable_o <= stable_i;
   end
endmodule // scs_osc_model

// ===== testbench/system_clock_select_and_startup_test.sv
// Self-checking bench for the clock select and start-up block.
// Assumes the oscillator model as the far side; shortened counts 8/16/4.
`timescale 1ns/1ns
module system_clock_select_and_startup_test;
   import scs_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] code = 4'h2;
   logic div8 = 1'b1, lng = 1'b0, half = 1'b0, stable = 1'b1;
   logic slp = 1'b0, wake = 1'b0, irq = 1'b0;
   scs_sleep_t mode = SLP_IDLE;
   logic eo, rc, ec, pll, wd, st, sys, core, pmem, peri, conv, fast, run, irqw, rsvd;
   logic [2:0] src;
   int err_total = 0, n_compared = 0, cyc = 0;
   int n_sys, n_core, n_pmem, n_peri, n_conv, n_fast;
   always #2 clk_i = ~clk_i;
   scs_osc_model u_scs_osc_model (.clk_i(clk_i), .stable_i(stable), .ext_osc_tick_o(eo),
      .rc_osc_tick_o(rc), .ext_clk_tick_o(ec), .pll_tick_o(pll), .watchdog_tick_o(wd),
      .osc_stable_o(st));
   scs_clock_ctrl #(.RESET_SHORT(8), .RESET_LONG(16), .WAKE_COUNT(4)) u_scs_clock_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .clock_source_select_code_i(code),
      .divide_by_eight_fuse_i(div8), .long_reset_timeout_i(lng), .ext_osc_tick_i(eo),
      .rc_osc_tick_i(rc), .ext_clk_tick_i(ec), .pll_tick_i(pll), .pll_half_rate_i(half),
      .watchdog_tick_i(wd), .osc_stable_i(st), .sleep_req_i(slp), .sleep_mode_i(mode),
      .wake_i(wake), .async_irq_i(irq), .pll_input_src_o(src), .system_tick_o(sys),
      .core_clock_o(core), .program_memory_clock_o(pmem), .peripheral_clock_o(peri),
      .converter_clock_o(conv), .fast_multiplied_clock_o(fast), .core_run_o(run),
      .irq_wake_o(irqw), .code_reserved_o(rsvd));
   task automatic give_verdict();
      if (err_total == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Hang guard: the whole run needs well under 5000 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
      n_compared++;
      if (exp !== got) begin
         err_total++;
         $display("[ERR] %s exp %0d got %0d", what, exp, got);
      end
   endtask
   // Count output pulses over n cycles, sampled just after each rising edge
   task automatic win(int n);
      n_sys = 0;
      n_core = 0;
      n_pmem = 0;
      n_peri = 0;
      n_conv = 0;
      n_fast = 0;
      repeat (n) begin
         @(posedge clk_i);
         #1;
         n_sys += sys;
         n_core += core;
         n_pmem += pmem;
         n_peri += peri;
         n_conv += conv;
         n_fast += fast;
      end
      @(negedge clk_i);
      chk("program_memory_clock_o", n_core, n_pmem);
   endtask
   task automatic wait_run(int lim);
      int k;
      k = 0;
      while (run !== 1'b1 && k < lim) begin
         @(negedge clk_i);
         k++;
      end
      chk("core_run_o", 1, run);
   endtask
   task automatic s_startup(logic l, int quiet);
      @(negedge clk_i);
      lng = l;
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (quiet) @(negedge clk_i);
      chk("core_run_o early", 0, run);
      wait_run(80);
   endtask
   task automatic s_codes();
      logic [2:0] exp_src [16] = '{1, 2, 1, 1, 0, 0, 4, 4, 1, 1, 1, 1, 1, 1, 1, 1};
      for (int i = 0; i < 16; i++) begin
         @(negedge clk_i);
         code = 4'(i);
         repeat (2) @(negedge clk_i);
         chk("pll_input_src_o", exp_src[i], src);
         chk("code_reserved_o", i == 6 || i == 7, rsvd);
      end
   endtask
   task automatic s_rate(logic [3:0] c, logic d8, int exp_n);
      @(negedge clk_i);
      code = c;
      div8 = d8;
      win(8);
      win(64);
      chk("system_tick_o", exp_n, n_sys);
      chk("core_clock_o", exp_n, n_core);
   endtask
   task automatic s_fast(logic h, int exp_n);
      @(negedge clk_i);
      half = h;
      win(8);
      win(64);
      chk("fast_multiplied_clock_o", exp_n, n_fast);
   endtask
   task automatic s_sleep(int m, int e_peri, int e_conv, int e_fast);
      @(negedge clk_i);
      mode = scs_sleep_t'(m);
      slp = 1'b1;
      @(negedge clk_i);
      slp = 1'b0;
      repeat (2) @(negedge clk_i);
      win(64);
      chk("core_clock_o asleep", 0, n_core);
      chk("peripheral_clock_o", e_peri, n_peri);
      chk("converter_clock_o", e_conv, n_conv);
      chk("fast_multiplied_clock_o", e_fast, n_fast);
      irq = 1'b1;
      repeat (2) @(negedge clk_i);
      chk("irq_wake_o", 1, irqw);
      irq = 1'b0;
      // Power-down wakes on an unsettled oscillator, power-save on a settled one
      stable = m != 2;
      wake = 1'b1;
      @(negedge clk_i);
      wake = 1'b0;
      if (m >= 2) begin
         // Three source ticks need at least five cycles, so run must still be low
         repeat (3) @(negedge clk_i);
         chk("core_run_o counting", 0, run);
         repeat (27) @(negedge clk_i);
         chk("core_run_o unstable", m == 3, run);
         stable = 1'b1;
      end
      wait_run(40);
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      s_startup(1'b0, 20);
      s_startup(1'b1, 52);
      s_codes();
      s_rate(4'h2, 1'b1, 32);
      s_rate(4'h2, 1'b0, 4);
      s_rate(4'h4, 1'b1, 16);
      s_rate(4'h0, 1'b1, 8);
      s_rate(4'hf, 1'b1, 16);
      s_rate(4'h3, 1'b1, 16);
      s_rate(4'h1, 1'b1, 16);
      s_rate(4'h5, 1'b1, 16);
      s_rate(4'h6, 1'b1, 0);
      s_rate(4'h2, 1'b1, 32);
      s_fast(1'b1, 32);
      s_fast(1'b0, 64);
      s_sleep(0, 32, 32, 64);
      s_sleep(1, 0, 32, 64);
      s_sleep(2, 0, 0, 0);
      s_sleep(3, 0, 0, 0);
      give_verdict();
   end
endmodule // system_clock_select_and_startup_test
